// ---- bench/plm_link_model.sv ----
// Behavioural link-layer controller facing the power manager
`include "plm_power_mgr_regs.svh"
module plm_link_model (
    input wire logic link_clk_i,
    input wire logic power_on_i,
    input wire logic ctrl_on_i,
    input wire logic [1:0] ctl_i,
    input wire logic [7:0] data_i,
    output logic link_power_status_out_o,
    output logic link_control_bit_o,
    output int groups_o = 0,
    output logic [7:0] last_group_o = 8'h00
);
    timeunit 1ns;
    timeprecision 1ps;
    // Status pin follows the link's own power, control bit set by its software
    assign link_power_status_out_o = power_on_i;
    assign link_control_bit_o = ctrl_on_i;
    // Only a receive code counts; idle or unknown lines are ignored
    always @(posedge link_clk_i) begin
        if (ctl_i === `PLM_CTL_RECEIVE) begin
            groups_o <= groups_o + 1;
            last_group_o <= data_i;
        end
    end
endmodule : plm_link_model

// ---- bench/tb_phy_link_power_manager.sv ----
// Self-checking testbench of the link power manager
module tb_phy_link_power_manager import plm_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    // Short reset is enough: the link side stays in reset until straps are caught
    localparam int RST_CYC = 4;
    logic clk_i = 0, lclk = 0, sys_rst_i = 1, pwr = 1, ctrl = 0;
    logic s0 = 0, s1 = 1, s2 = 0, rx_valid = 0, rx_bit = 0, lon_pkt = 0;
    logic phy_int = 0, int_en = 0, bus_rst = 0, sid_done = 0, lreq = 0;
    logic [2:0] pclass = 3'h2, beta = 3'h7, conn = 3'h7, act = 3'h3;
    logic [5:0] pspeed = 6'h05, sid_val = 6'h00;
    logic [1:0] rx_port = 2'h0, rx_speed = 2'h0;
    logic lps, lctl, tx_bit, pclk_en, br_o, sid_bit, lon, lcs, nid_v, lacc;
    logic [2:0] pbeta, tx_en;
    logic [8:0] pspd;
    logic [1:0] ifs, ctl;
    logic [5:0] nid;
    logic [7:0] data, last_group;
    int groups, err_total = 0, n_checks = 0, br_cnt = 0, r;

    always #5 clk_i = ~clk_i;
    always #32 lclk = ~lclk;
    always @(posedge clk_i) if (br_o === 1'b1) br_cnt <= br_cnt + 1;

    // Disable threshold outlasts the reset-state checks
    plm_power_mgr #(.RESET_DETECT_CYC(8), .DISABLE_DETECT_CYC(300), .LINK_ON_REQUEST_HALF_CYC(4),
        .POWERUP_CYC(100)) dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .link_clk_i(lclk),
        .link_power_status_in_i(lps), .link_control_bit_i(lctl),
        .strobe_only_strap_port0_i(s0), .strobe_only_strap_port1_i(s1),
        .strobe_only_strap_port2_i(s2), .power_class_i(pclass), .peer_beta_i(beta),
        .peer_speed_i(pspeed), .port_connected_i(conn), .port_active_i(act),
        .rx_valid_i(rx_valid), .rx_bit_i(rx_bit), .rx_port_i(rx_port),
        .rx_speed_i(rx_speed), .link_on_packet_i(lon_pkt), .phy_int_i(phy_int),
        .int_wake_en_i(int_en), .bus_reset_i(bus_rst), .self_id_done_i(sid_done),
        .self_id_value_i(sid_val), .lreq_i(lreq), .port_beta_o(pbeta),
        .port_speed_o(pspd), .tx_en_o(tx_en), .tx_bit_o(tx_bit), .iface_state_o(ifs),
        .pclk_enable_o(pclk_en), .bus_reset_o(br_o), .self_id_link_bit_o(sid_bit),
        .link_on_request_o(lon), .link_control_status_o(lcs), .node_identifier_o(nid),
        .node_id_valid_o(nid_v), .ctl_o(ctl), .data_o(data), .lreq_accept_o(lacc));

    plm_link_model link (.link_clk_i(lclk), .power_on_i(pwr), .ctrl_on_i(ctrl),
        .ctl_i(ctl), .data_i(data), .link_power_status_out_o(lps),
        .link_control_bit_o(lctl), .groups_o(groups), .last_group_o(last_group));

    task automatic complete_run();
        if (err_total == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : complete_run

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic cyc(input int n);
        repeat (n) @(negedge clk_i);
    endtask : cyc

    task automatic pulse(ref logic s);
        s = 1'b1;
        cyc(1);
        s = 1'b0;
    endtask : pulse

    // Square wave gives 4 to 6 rising edges in 40 cycles at a period of 8
    task automatic wave(input int n, input logic running);
        logic prev;
        r = 0;
        prev = lon;
        repeat (n) begin
            @(negedge clk_i);
            if (lon === 1'b1 && prev !== 1'b1) r++;
            prev = lon;
        end
        if (running) check("link_on_rises", 32'h1, 32'(r >= 4 && r <= 6));
        else check("link_on_idle", 32'h0, 32'(r) | 32'(lon));
    endtask : wave

    task automatic wait_state(input logic [1:0] exp, input int limit);
        for (int i = 0; i < limit && ifs !== exp; i++) @(negedge clk_i);
        check("iface_state_o", 32'(exp), 32'(ifs));
    endtask : wait_state

    // Bits go out MSB first; every bit must be repeated one cycle later
    task automatic rx_group(input logic [1:0] spd, input logic [7:0] val, input int w,
            input logic seen);
        int g0;
        g0 = groups;
        rx_speed = spd;
        for (int i = w - 1; i >= 0; i--) begin
            rx_valid = 1'b1;
            rx_bit = val[i];
            @(posedge clk_i);
            #1;
            check("tx_en_o", 32'h2, 32'(tx_en));
            check("tx_bit_o", 32'(val[i]), 32'(tx_bit));
            @(negedge clk_i);
        end
        rx_valid = 1'b0;
        for (int i = 0; i < 80 && groups == g0; i++) @(negedge clk_i);
        if (seen) check("rx_group", 32'(val), 32'(last_group & 8'((1 << w) - 1)));
        check("groups", 32'(g0 + int'(seen)), 32'(groups));
        cyc(2);
    endtask : rx_group

    initial begin
        #200000;
        err_total++;
        complete_run();
    end

    initial begin
        repeat (RST_CYC) @(negedge clk_i);
        check("iface_state_o", 32'(IF_DISABLED), 32'(ifs));
        check("pclk_enable_o", 32'h0, 32'(pclk_en));
        sys_rst_i = 1'b0;
        wait_state(IF_ACTIVE, 20);
        wave(40, 1'b1);
        check("port_beta_o", 32'h5, 32'(pbeta));
        check("port_speed_o", 32'({3'h3, 3'h1, 3'h4}), 32'(pspd));
        ctrl = 1'b1;
        cyc(4);
        wave(20, 1'b0);
        check("self_id_link_bit_o", 32'h1, 32'(sid_bit));
        check("link_control_status_o", 32'h1, 32'(lcs));
        beta = 3'h0;
        pspeed = 6'h23;
        cyc(5);
        check("port_beta_o", 32'h0, 32'(pbeta));
        check("port_speed_o", 32'({3'h2, 3'h0, 3'h2}), 32'(pspd));
        rx_group(2'h0, 8'h02, 2, 1'b1);
        rx_group(2'h1, 8'h0B, 4, 1'b1);
        rx_group(2'h2, 8'hA5, 8, 1'b1);
        lreq = 1'b1;
        cyc(12);
        check("lreq_accept_o", 32'h1, 32'(lacc));
        lreq = 1'b0;
        ctrl = 1'b0;
        cyc(20);
        check("iface_state_o", 32'(IF_ACTIVE), 32'(ifs));
        ctrl = 1'b1;
        pwr = 1'b0;
        cyc(5);
        pwr = 1'b1;
        cyc(15);
        check("iface_state_o", 32'(IF_ACTIVE), 32'(ifs));
        pwr = 1'b0;
        cyc(6);
        check("iface_state_o", 32'(IF_ACTIVE), 32'(ifs));
        wait_state(IF_RESET, 20);
        check("pclk_enable_o", 32'h1, 32'(pclk_en));
        cyc(30);
        lreq = 1'b1;
        cyc(12);
        check("lreq_accept_o", 32'h0, 32'(lacc));
        lreq = 1'b0;
        rx_group(2'h1, 8'h06, 4, 1'b0);
        pwr = 1'b1;
        wait_state(IF_ACTIVE, 20);
        cyc(5);
        check("bus_reset_pulses", 32'h0, 32'(br_cnt));
        pwr = 1'b0;
        wait_state(IF_DISABLED, 400);
        cyc(2);
        check("pclk_enable_o", 32'h0, 32'(pclk_en));
        rx_group(2'h0, 8'h01, 2, 1'b0);
        pwr = 1'b1;
        wait_state(IF_ACTIVE, 20);
        cyc(5);
        check("bus_reset_pulses", 32'h1, 32'(br_cnt));
        pulse(lon_pkt);
        wave(40, 1'b0);
        ctrl = 1'b0;
        cyc(3);
        pulse(lon_pkt);
        wave(40, 1'b1);
        pulse(bus_rst);
        cyc(3);
        wave(30, 1'b0);
        phy_int = 1'b1;
        int_en = 1'b1;
        cyc(2);
        wave(40, 1'b1);
        pulse(bus_rst);
        cyc(2);
        wave(40, 1'b1);
        ctrl = 1'b1;
        cyc(4);
        wave(30, 1'b0);
        phy_int = 1'b0;
        int_en = 1'b0;
        sid_val = 6'h2A;
        pulse(sid_done);
        cyc(1);
        check("node_identifier_o", 32'h2A, 32'(nid));
        check("node_id_valid_o", 32'h1, 32'(nid_v));
        pulse(bus_rst);
        cyc(1);
        check("node_id_valid_o", 32'h0, 32'(nid_v));
        complete_run();
    end
endmodule : tb_phy_link_power_manager

// ---- hdl/plm_pkg.sv ----
// Types shared by the link power manager
package plm_pkg;
    typedef enum logic [1:0] {
        IF_DISABLED = 2'h0,
        IF_INIT = 2'h1,
        IF_ACTIVE = 2'h3,
        IF_RESET = 2'h2
    } plm_if_state_t;
    typedef enum logic [2:0] {
        SPD_S100 = 3'h0,
        SPD_S200 = 3'h1,
        SPD_S400 = 3'h2,
        SPD_S400B = 3'h3,
        SPD_S800 = 3'h4
    } plm_speed_t;
endpackage : plm_pkg

// ---- hdl/plm_power_mgr.sv ----
// Link power, wake request and port mode control of a three-port bus PHY
// What this block does
// - Legacy peer: data-strobe port at S100-S400
// - Newer peer: bilingual port at S400B or S800
// - Strap low bilingual, high forces legacy only
// - Deserialize received bits into 2/4/8-bit groups
// - Repeat received data on other active ports
// - Status inactive only after low past threshold
// - Reset state: CTL, D zero, LREQ ignored
// - Low past disable threshold: disabled, clock stopped
// - Interface state follows status input only
// - Repeating continues whatever the interface state
// - Status active again reinitializes the interface
// - Hardware reset holds interface disabled
// - Leaving disabled state issues bus reset, except after hardware reset
// - Link-on output toggles as square wave
// - Wake while link inactive asserts link-on
// - Link-on packet or enabled interrupt wakes
// - Link active and control bit clear link-on
// - Bus reset clears wake link-on unless interrupt, not power-up link-on
// - Power-up low class: link-on for 167 ms
// - Report control bit and node identifier validity
`include "plm_power_mgr_regs.svh"
module plm_power_mgr
    import plm_pkg::*;
#(
    parameter int unsigned RESET_DETECT_CYC = `PLM_RESET_DETECT_CYC,
    parameter int unsigned DISABLE_DETECT_CYC = `PLM_DISABLE_DETECT_CYC,
    parameter int unsigned LINK_ON_REQUEST_HALF_CYC = `PLM_LINK_ON_REQUEST_HALF_CYC,
    parameter int unsigned POWERUP_CYC = `PLM_POWERUP_CYC
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic link_clk_i,
    input wire logic link_power_status_in_i,
    input wire logic link_control_bit_i,
    input wire logic strobe_only_strap_port0_i,
    input wire logic strobe_only_strap_port1_i,
    input wire logic strobe_only_strap_port2_i,
    input wire logic [2:0] power_class_i,
    input wire logic [2:0] peer_beta_i,
    input wire logic [5:0] peer_speed_i,
    input wire logic [2:0] port_connected_i,
    input wire logic [2:0] port_active_i,
    input wire logic rx_valid_i,
    input wire logic rx_bit_i,
    input wire logic [1:0] rx_port_i,
    input wire logic [1:0] rx_speed_i,
    input wire logic link_on_packet_i,
    input wire logic phy_int_i,
    input wire logic int_wake_en_i,
    input wire logic bus_reset_i,
    input wire logic self_id_done_i,
    input wire logic [5:0] self_id_value_i,
    input wire logic lreq_i,
    output logic [2:0] port_beta_o,
    output logic [8:0] port_speed_o,
    output logic [2:0] tx_en_o,
    output logic tx_bit_o,
    output logic [1:0] iface_state_o,
    output logic pclk_enable_o,
    output logic bus_reset_o,
    output logic self_id_link_bit_o,
    output logic link_on_request_o,
    output logic link_control_status_o,
    output logic [5:0] node_identifier_o,
    output logic node_id_valid_o,
    output logic [1:0] ctl_o,
    output logic [7:0] data_o,
    output logic lreq_accept_o
);
    localparam int LINK_ON_REQUEST_MAX = 128;
    function automatic plm_speed_t pick_speed(input logic strap, input logic beta,
                                              input logic [1:0] peer);
        if (!strap && beta) begin
            pick_speed = (peer == 2'h0) ? SPD_S400B : SPD_S800;
        end else begin
            case (peer)
                2'h0: pick_speed = SPD_S100;
                2'h1: pick_speed = SPD_S200;
                default: pick_speed = SPD_S400;
            endcase
        end
    endfunction : pick_speed
    // Pin synchronisers
    logic lps_meta_reg, lps_sync_reg;
    logic [2:0] strap_meta_reg, strap_sync_reg, strap_reg;
    logic straps_taken_reg;
    always_ff @(posedge clk_i) begin
        lps_meta_reg <= link_power_status_in_i;
        lps_sync_reg <= lps_meta_reg;
        strap_meta_reg <= {strobe_only_strap_port2_i, strobe_only_strap_port1_i,
                           strobe_only_strap_port0_i};
        strap_sync_reg <= strap_meta_reg;
    end
    // Straps caught once after release; sync stage must settle first
    logic [1:0] settle_reg;
    logic powerup_start;
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            settle_reg <= 2'h0;
            straps_taken_reg <= 1'b0;
            strap_reg <= 3'h7;
        end else begin
            if (settle_reg != 2'h3) begin
                settle_reg <= settle_reg + 2'h1;
            end else if (!straps_taken_reg) begin
                straps_taken_reg <= 1'b1;
                strap_reg <= strap_sync_reg;
            end
        end
    end
    assign powerup_start = (settle_reg == 2'h3) && !straps_taken_reg;
    // Port mode per port and repeating
    genvar p;
    generate
        for (p = 0; p < 3; p++) begin : g_port
            always_ff @(posedge clk_i) begin
                if (sys_rst_i) begin
                    port_beta_o[p] <= 1'b0;
                    port_speed_o[3*p +: 3] <= SPD_S100;
                    tx_en_o[p] <= 1'b0;
                end else begin
                    port_beta_o[p] <= !strap_reg[p] && peer_beta_i[p];
                    port_speed_o[3*p +: 3] <= pick_speed(strap_reg[p], peer_beta_i[p],
                                                         peer_speed_i[2*p +: 2]);
                    // No interface term here: repeating never waits on the link
                    tx_en_o[p] <= rx_valid_i && port_connected_i[p] && port_active_i[p]
                                  && (rx_port_i != 2'(p));
                end
            end
        end
    endgenerate
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            tx_bit_o <= 1'b0;
        end else begin
            tx_bit_o <= rx_bit_i;
        end
    end
    // Low time of the status input
    logic [31:0] low_cnt_reg;
    logic lps_active;
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || lps_sync_reg) begin
            low_cnt_reg <= 32'h0;
        end else if (low_cnt_reg <= DISABLE_DETECT_CYC) begin
            low_cnt_reg <= low_cnt_reg + 32'h1;
        end
    end
    assign lps_active = (low_cnt_reg <= RESET_DETECT_CYC);
    // Interface state: control bit deliberately absent from this logic
    plm_if_state_t state_reg, state_next;
    logic lps_disabled_reg;
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            IF_DISABLED: if (lps_active) state_next = IF_INIT;
            IF_INIT: state_next = IF_ACTIVE;
            IF_ACTIVE: if (!lps_active) state_next = IF_RESET;
            IF_RESET: begin
                if (lps_active) begin
                    state_next = IF_INIT;
                end else if (low_cnt_reg > DISABLE_DETECT_CYC) begin
                    state_next = IF_DISABLED;
                end
            end
            default: state_next = IF_DISABLED;
        endcase
    end
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            state_reg <= IF_DISABLED;
            lps_disabled_reg <= 1'b0;
            bus_reset_o <= 1'b0;
        end else begin
            state_reg <= state_next;
            bus_reset_o <= (state_reg == IF_DISABLED) && lps_active
                           && lps_disabled_reg;
            if (state_reg == IF_RESET && state_next == IF_DISABLED) begin
                lps_disabled_reg <= 1'b1;
            end else if (state_reg == IF_DISABLED && lps_active) begin
                lps_disabled_reg <= 1'b0;
            end
        end
    end
    assign iface_state_o = state_reg;
    logic iface_on_reg;
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            pclk_enable_o <= 1'b0;
            iface_on_reg <= 1'b0;
            self_id_link_bit_o <= 1'b0;
            link_control_status_o <= 1'b0;
        end else begin
            pclk_enable_o <= (state_reg != IF_DISABLED);
            iface_on_reg <= (state_reg == IF_ACTIVE);
            self_id_link_bit_o <= lps_active && link_control_bit_i;
            link_control_status_o <= link_control_bit_i;
        end
    end
    // Link-on wake request
    logic wake, link_inactive, any_reset, int_hold;
    logic wake_req_reg, powerup_req_reg;
    logic [31:0] powerup_cnt_reg;
    assign wake = link_on_packet_i || (phy_int_i && int_wake_en_i);
    assign link_inactive = !lps_active || !link_control_bit_i;
    assign any_reset = bus_reset_i || bus_reset_o;
    assign int_hold = phy_int_i && int_wake_en_i && link_inactive;
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            wake_req_reg <= 1'b0;
        end else if (wake && link_inactive) begin
            wake_req_reg <= 1'b1;
        end else if (!link_inactive) begin
            wake_req_reg <= 1'b0;
        end else if (any_reset && !int_hold) begin
            wake_req_reg <= 1'b0;
        end
    end
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            powerup_req_reg <= 1'b0;
            powerup_cnt_reg <= 32'h0;
        end else if (powerup_start) begin
            powerup_req_reg <= (power_class_i <= `PLM_PWR_CLASS_MAX);
            powerup_cnt_reg <= 32'h0;
        end else if (powerup_req_reg) begin
            powerup_cnt_reg <= powerup_cnt_reg + 32'h1;
            if (!link_inactive || powerup_cnt_reg >= POWERUP_CYC - 32'h1) begin
                powerup_req_reg <= 1'b0;
            end
        end
    end
    logic [31:0] half_cnt_reg;
    logic link_on_request_req;
    assign link_on_request_req = wake_req_reg || powerup_req_reg;
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || !link_on_request_req) begin
            half_cnt_reg <= 32'h0;
            link_on_request_o <= 1'b0;
        end else if (half_cnt_reg >= LINK_ON_REQUEST_HALF_CYC - 32'h1) begin
            half_cnt_reg <= 32'h0;
            link_on_request_o <= !link_on_request_o;
        end else begin
            half_cnt_reg <= half_cnt_reg + 32'h1;
        end
    end
    // Node identifier validity
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            node_identifier_o <= `PLM_NODE_ID_RESET;
            node_id_valid_o <= 1'b0;
        end else if (any_reset) begin
            node_id_valid_o <= 1'b0;
        end else if (self_id_done_i) begin
            node_identifier_o <= self_id_value_i;
            node_id_valid_o <= 1'b1;
        end
    end
    // Receive deserializer; a group arriving while one is in flight is dropped
    logic [7:0] shift_reg, grp_data_reg;
    logic [2:0] bit_cnt_reg, grp_last;
    logic grp_req_reg, ack_meta_reg, ack_sync_reg, link_ack_reg;
    always_comb begin
        case (rx_speed_i)
            2'h0: grp_last = `PLM_GRP_LAST_2;
            2'h1: grp_last = `PLM_GRP_LAST_4;
            default: grp_last = `PLM_GRP_LAST_8;
        endcase
    end
    always_ff @(posedge clk_i) begin
        ack_meta_reg <= link_ack_reg;
        ack_sync_reg <= ack_meta_reg;
    end
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            shift_reg <= 8'h00;
            bit_cnt_reg <= 3'h0;
            grp_data_reg <= 8'h00;
            grp_req_reg <= 1'b0;
        end else if (!rx_valid_i) begin
            bit_cnt_reg <= 3'h0;
        end else begin
            shift_reg <= {shift_reg[6:0], rx_bit_i};
            if (bit_cnt_reg == grp_last) begin
                bit_cnt_reg <= 3'h0;
                if (grp_req_reg == ack_sync_reg) begin
                    grp_data_reg <= {shift_reg[6:0], rx_bit_i};
                    grp_req_reg <= !grp_req_reg;
                end
            end else begin
                bit_cnt_reg <= bit_cnt_reg + 3'h1;
            end
        end
    end
    // Link clock domain; reset held until straps caught, so short resets reach it
    logic lrst_meta_reg, lrst_reg, on_meta_reg, on_sync_reg, req_meta_reg, req_sync_reg;
    always_ff @(posedge link_clk_i) begin
        lrst_meta_reg <= !straps_taken_reg;
        lrst_reg <= lrst_meta_reg;
        on_meta_reg <= iface_on_reg;
        on_sync_reg <= on_meta_reg;
        req_meta_reg <= grp_req_reg;
        req_sync_reg <= req_meta_reg;
    end
    always_ff @(posedge link_clk_i) begin
        if (lrst_reg) begin
            link_ack_reg <= 1'b0;
            ctl_o <= `PLM_CTL_IDLE;
            data_o <= `PLM_DATA_IDLE;
            lreq_accept_o <= 1'b0;
        end else begin
            link_ack_reg <= req_sync_reg;
            lreq_accept_o <= on_sync_reg && lreq_i;
            if (on_sync_reg && (req_sync_reg != link_ack_reg)) begin
                ctl_o <= `PLM_CTL_RECEIVE;
                data_o <= grp_data_reg;
            end else begin
                ctl_o <= `PLM_CTL_IDLE;
                data_o <= `PLM_DATA_IDLE;
            end
        end
    end

    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    lps_active_a: assert property (lps_sync_reg |=> lps_active)
        else $error("status not active after input seen high");
    reset_enter_a: assert property (state_reg == IF_ACTIVE && !lps_active
            |=> state_reg == IF_RESET ##1 pclk_enable_o)
        else $error("reset state not entered with clock running");
    clock_stop_a: assert property (state_reg == IF_DISABLED |=> !pclk_enable_o)
        else $error("clock runs in disabled state");
    hw_reset_hold_a: assert property (@(posedge clk_i) disable iff (1'b0)
            sys_rst_i |=> state_reg == IF_DISABLED)
        else $error("interface not disabled under reset");
    bus_reset_issue_a: assert property (state_reg == IF_DISABLED && lps_active && lps_disabled_reg
            |=> bus_reset_o ##1 state_reg == IF_ACTIVE)
        else $error("no bus reset on return from disabled");
    link_on_request_set_a: assert property (wake && link_inactive |=> wake_req_reg)
        else $error("wake lost while link inactive");
    link_on_request_clear_a: assert property (!link_inactive && !wake_req_reg && !powerup_req_reg
            |=> !link_on_request_o)
        else $error("link-on stays up with link active");
    link_on_request_wave_a: assert property ($rose(link_on_request_req) |-> ##[1:LINK_ON_REQUEST_MAX] link_on_request_o)
        else $error("link-on never toggles high");
    repeat_port_a: assert property (rx_valid_i && port_connected_i[1] && port_active_i[1]
            && rx_port_i != 2'h1 |=> tx_en_o[1])
        else $error("received data not repeated");
    node_invalid_a: assert property (any_reset |=> !node_id_valid_o)
        else $error("node id valid after bus reset");
    strap_legacy_a: assert property (straps_taken_reg && strap_reg[1] |=> !port_beta_o[1])
        else $error("newer signaling on strapped port");
    link_quiet_a: assert property (@(posedge link_clk_i) disable iff (lrst_reg)
            !on_sync_reg |=> ctl_o == `PLM_CTL_IDLE && data_o == `PLM_DATA_IDLE)
        else $error("link outputs not held low");

    reset_state_c: cover property (state_reg == IF_ACTIVE ##1 state_reg == IF_RESET);
    disabled_c: cover property (state_reg == IF_RESET ##1 state_reg == IF_DISABLED);
    bus_reset_c: cover property (bus_reset_o);
    link_on_request_c: cover property ($rose(link_on_request_o));
endmodule : plm_power_mgr

// ---- hdl/plm_power_mgr_regs.svh ----
// Timing counts and field constants for the link power manager
`ifndef PLM_POWER_MGR_REGS_SVH
`define PLM_POWER_MGR_REGS_SVH
`define PLM_CLK_MHZ 32'h64
`define PLM_POWERUP_MS 32'hA7
`define PLM_US_PER_MS 32'h3E8
`define PLM_POWERUP_CYC (`PLM_POWERUP_MS * `PLM_US_PER_MS * `PLM_CLK_MHZ)
`define PLM_RESET_DETECT_CYC 32'h100
`define PLM_DISABLE_DETECT_CYC 32'h9C4
`define PLM_LINK_ON_REQUEST_HALF_CYC 32'h32
`define PLM_PWR_CLASS_MAX 3'h4
`define PLM_CTL_IDLE 2'h0
`define PLM_CTL_RECEIVE 2'h2
`define PLM_DATA_IDLE 8'h00
`define PLM_NODE_ID_RESET 6'h00
`define PLM_GRP_LAST_2 3'h1
`define PLM_GRP_LAST_4 3'h3
`define PLM_GRP_LAST_8 3'h7
`endif
